// ---- hdl/ptmux_consts.svh ----
// Register offsets, reset values and field positions of the port 3-5 block
`ifndef PTMUX_CONSTS_SVH
`define PTMUX_CONSTS_SVH
`define PTMUX_ADDR_P3_DIR 16'hFE84
`define PTMUX_ADDR_P4_DIR 16'hFE85
`define PTMUX_ADDR_P3_LAT 16'hFE86
`define PTMUX_ADDR_P4_LAT 16'hFE87
`define PTMUX_ADDR_P5_DIR 16'hFE88
`define PTMUX_ADDR_P5_LAT 16'hFE8A
`define PTMUX_ADDR_BRC 16'hFF1B
`define PTMUX_ADDR_PERIPH 16'hFF80
`define PTMUX_PORT_RST 8'h00
`define PTMUX_BRC_RST 8'hFE
`define PTMUX_DIR_READ 8'hFF
`define PTMUX_UNMAPPED_READ 8'h00
`define PTMUX_BIT_BUS_RELEASE_ENABLE 0
`define PTMUX_BIT_WAITSEL 0
`define PTMUX_BIT_EXT_TRIGGER_ENABLE 1
`define PTMUX_BIT_T8OE 2
`define PTMUX_BIT_T1OEA 3
`define PTMUX_BIT_T1OEB 4
`define PTMUX_BIT_T2OEA 5
`define PTMUX_BIT_T2OEB 6
`define PTMUX_PIN_BACK 1
`define PTMUX_PIN_BUS_REQUEST_INPUT 2
`define PTMUX_PIN_WAIT 0
`endif

// ---- hdl/ptmux_pkg.sv ----
// Types shared by the port 3-5 block
package ptmux_pkg;
    typedef enum logic [1:0] {
        PTMUX_RUN = 2'b00,
        PTMUX_SW_STBY = 2'b01,
        PTMUX_HW_STBY = 2'b10
    } ptmux_pmode_t;
endpackage

// ---- hdl/ptmux_top.sv ----
// Ports 3, 4 and 5 with their pin sharing to bus, timer and converter logic
`timescale 1ns/1ps
`default_nettype none
`include "ptmux_consts.svh"
// Overview of operation
// [RULE_01] Release enable: P3.2 request in, P3.1 grant out
// [RULE_02] Release disabled (reset): P3.2, P3.1 plain GPIO
// [RULE_03] Wait select makes P3.0 wait input
// [RULE_04] GPIO pin drives latch when direction 1
// [RULE_05] Direction registers write-only, read all ones
// [RULE_06] Reset, hardware standby clear; software standby keeps
// [RULE_07] Data read: latch for outputs, pin otherwise
// [RULE_08] Software standby drops peripheral pin ownership
// [RULE_09] P4.7, P4.5 feed timer external clocks
// [RULE_10] P4.3 outputs 8-bit timer wave when selected
// [RULE_11] P4.2 feeds 8-bit timer reset input
// [RULE_12] P4.1 feeds 8-bit timer clock input
// [RULE_13] Trigger enable makes P4.0 converter trigger
// [RULE_14] P5.3, P5.2 output timer two compares
// [RULE_15] P5.1, P5.0 output timer one compares
// [RULE_16] Pin selection identical in every chip mode
// [RULE_17] P4.6, P4.4 feed timer capture inputs
// [RULE_18] Release control resets FE, upper bits read one
module ptmux_top #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] power_mode,
    input wire logic wait_pin_select,
    input wire logic [WIDTH-1:0] p3_in,
    output logic [WIDTH-1:0] p3_out,
    output logic [WIDTH-1:0] p3_oe,
    input wire logic [WIDTH-1:0] p4_in,
    output logic [WIDTH-1:0] p4_out,
    output logic [WIDTH-1:0] p4_oe,
    input wire logic [WIDTH-1:0] p5_in,
    output logic [WIDTH-1:0] p5_out,
    output logic [WIDTH-1:0] p5_oe,
    input wire logic bus_grant_out,
    output logic bus_request_input,
    output logic wait_request_in,
    output logic timer_one_ext_clock_in,
    output logic timer_two_ext_clock_in,
    output logic timer_one_capture_in,
    output logic timer_two_capture_in,
    input wire logic timer8_wave_output,
    output logic timer8_reset_input,
    output logic timer8_clock_input,
    output logic converter_trigger_input,
    input wire logic timer_one_compare_out_a,
    input wire logic timer_one_compare_out_b,
    input wire logic timer_two_compare_out_a,
    input wire logic timer_two_compare_out_b
);
    logic [WIDTH-1:0] p3_dir_ff, p4_dir_ff, p5_dir_ff;
    logic [WIDTH-1:0] p3_lat_ff, p4_lat_ff, p5_lat_ff;
    logic bus_release_enable_ff;
    logic [6:0] periph_sel_ff;
    logic [7:0] nxt_rdata;
    logic [WIDTH-1:0] nxt_p3_out, nxt_p3_oe, nxt_p4_out, nxt_p4_oe;
    logic [WIDTH-1:0] nxt_p5_out, nxt_p5_oe;
    logic hw_stby, sw_stby;

    // Mode decode; the chip operating mode does not enter here at all
    assign hw_stby = (power_mode == ptmux_pkg::PTMUX_HW_STBY); // [RULE_16]
    assign sw_stby = (power_mode == ptmux_pkg::PTMUX_SW_STBY);

    // Direction and latch registers; hardware standby clears like reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            p3_dir_ff <= `PTMUX_PORT_RST;
            p4_dir_ff <= `PTMUX_PORT_RST;
            p5_dir_ff <= `PTMUX_PORT_RST;
            p3_lat_ff <= `PTMUX_PORT_RST;
            p4_lat_ff <= `PTMUX_PORT_RST;
            p5_lat_ff <= `PTMUX_PORT_RST;
        end else if (hw_stby) begin
            p3_dir_ff <= `PTMUX_PORT_RST; // [RULE_06]
            p4_dir_ff <= `PTMUX_PORT_RST;
            p5_dir_ff <= `PTMUX_PORT_RST;
            p3_lat_ff <= `PTMUX_PORT_RST;
            p4_lat_ff <= `PTMUX_PORT_RST;
            p5_lat_ff <= `PTMUX_PORT_RST;
        end else if (reg_wr) begin
            // Writes still land in software standby: only clocks stop there
            unique case (reg_addr)
                `PTMUX_ADDR_P3_DIR: p3_dir_ff <= reg_wdata[WIDTH-1:0];
                `PTMUX_ADDR_P4_DIR: p4_dir_ff <= reg_wdata[WIDTH-1:0];
                `PTMUX_ADDR_P5_DIR: p5_dir_ff <= reg_wdata[WIDTH-1:0];
                `PTMUX_ADDR_P3_LAT: p3_lat_ff <= reg_wdata[WIDTH-1:0];
                `PTMUX_ADDR_P4_LAT: p4_lat_ff <= reg_wdata[WIDTH-1:0];
                `PTMUX_ADDR_P5_LAT: p5_lat_ff <= reg_wdata[WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Bus release control: only bit 0 is storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_release_enable_ff <= 1'b0;
        end else if (hw_stby) begin
            bus_release_enable_ff <= 1'b0; // [RULE_18]
        end else if (reg_wr && reg_addr == `PTMUX_ADDR_BRC) begin
            bus_release_enable_ff <= reg_wdata[`PTMUX_BIT_BUS_RELEASE_ENABLE];
        end
    end

    // Peripheral pin-select bits held in a local register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            periph_sel_ff <= 7'h00;
        end else if (hw_stby || sw_stby) begin
            // Modules are initialised on standby entry, releasing pins
            periph_sel_ff <= 7'h00; // [RULE_08]
        end else if (reg_wr && reg_addr == `PTMUX_ADDR_PERIPH) begin
            periph_sel_ff <= reg_wdata[6:0];
        end
    end

    // Read mux; data reads mix latch and live pin per direction bit
    always_comb begin
        nxt_rdata = `PTMUX_UNMAPPED_READ;
        unique case (reg_addr)
            `PTMUX_ADDR_P3_DIR, `PTMUX_ADDR_P4_DIR, `PTMUX_ADDR_P5_DIR:
                nxt_rdata = `PTMUX_DIR_READ; // [RULE_05]
            `PTMUX_ADDR_P3_LAT:
                nxt_rdata = (p3_lat_ff & p3_dir_ff) | (p3_in & ~p3_dir_ff); // [RULE_07]
            `PTMUX_ADDR_P4_LAT:
                nxt_rdata = (p4_lat_ff & p4_dir_ff) | (p4_in & ~p4_dir_ff); // [RULE_07]
            `PTMUX_ADDR_P5_LAT:
                nxt_rdata = (p5_lat_ff & p5_dir_ff) | (p5_in & ~p5_dir_ff); // [RULE_07]
            `PTMUX_ADDR_BRC:
                nxt_rdata = {7'h7F, bus_release_enable_ff}; // [RULE_18]
            `PTMUX_ADDR_PERIPH:
                nxt_rdata = {1'b0, periph_sel_ff};
            default: nxt_rdata = `PTMUX_UNMAPPED_READ;
        endcase
    end

    // Read data is valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // Pin drive: general-purpose first, then peripheral overrides
    always_comb begin
        nxt_p3_out = p3_lat_ff; // [RULE_04]
        nxt_p3_oe = p3_dir_ff; // [RULE_02]
        nxt_p4_out = p4_lat_ff;
        nxt_p4_oe = p4_dir_ff;
        nxt_p5_out = p5_lat_ff;
        nxt_p5_oe = p5_dir_ff;
        if (bus_release_enable_ff) begin
            nxt_p3_oe[`PTMUX_PIN_BUS_REQUEST_INPUT] = 1'b0; // [RULE_01]
            nxt_p3_out[`PTMUX_PIN_BACK] = bus_grant_out;
            nxt_p3_oe[`PTMUX_PIN_BACK] = 1'b1;
        end
        if (wait_pin_select) begin
            nxt_p3_oe[`PTMUX_PIN_WAIT] = 1'b0; // [RULE_03]
        end
        if (periph_sel_ff[`PTMUX_BIT_T8OE]) begin
            nxt_p4_out[3] = timer8_wave_output; // [RULE_10]
            nxt_p4_oe[3] = 1'b1;
        end
        if (periph_sel_ff[`PTMUX_BIT_EXT_TRIGGER_ENABLE]) begin
            nxt_p4_oe[0] = 1'b0; // [RULE_13]
        end
        if (periph_sel_ff[`PTMUX_BIT_T2OEB]) begin
            nxt_p5_out[3] = timer_two_compare_out_b; // [RULE_14]
            nxt_p5_oe[3] = 1'b1;
        end
        if (periph_sel_ff[`PTMUX_BIT_T2OEA]) begin
            nxt_p5_out[2] = timer_two_compare_out_a; // [RULE_14]
            nxt_p5_oe[2] = 1'b1;
        end
        if (periph_sel_ff[`PTMUX_BIT_T1OEB]) begin
            nxt_p5_out[1] = timer_one_compare_out_b; // [RULE_15]
            nxt_p5_oe[1] = 1'b1;
        end
        if (periph_sel_ff[`PTMUX_BIT_T1OEA]) begin
            nxt_p5_out[0] = timer_one_compare_out_a; // [RULE_15]
            nxt_p5_oe[0] = 1'b1;
        end
    end

    // Registered pin drive; costs one cycle of latency on every change
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            p3_out <= `PTMUX_PORT_RST;
            p3_oe <= `PTMUX_PORT_RST;
            p4_out <= `PTMUX_PORT_RST;
            p4_oe <= `PTMUX_PORT_RST;
            p5_out <= `PTMUX_PORT_RST;
            p5_oe <= `PTMUX_PORT_RST;
        end else begin
            p3_out <= nxt_p3_out;
            p3_oe <= nxt_p3_oe;
            p4_out <= nxt_p4_out;
            p4_oe <= nxt_p4_oe;
            p5_out <= nxt_p5_out;
            p5_oe <= nxt_p5_oe;
        end
    end

    // Inputs to on-chip modules; request and wait idle high when unowned
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_request_input <= 1'b1;
            wait_request_in <= 1'b1;
            converter_trigger_input <= 1'b1;
            timer_one_ext_clock_in <= 1'b0;
            timer_two_ext_clock_in <= 1'b0;
            timer_one_capture_in <= 1'b0;
            timer_two_capture_in <= 1'b0;
            timer8_reset_input <= 1'b0;
            timer8_clock_input <= 1'b0;
        end else begin
            bus_request_input <= bus_release_enable_ff ? p3_in[`PTMUX_PIN_BUS_REQUEST_INPUT] : 1'b1; // [RULE_01]
            wait_request_in <= wait_pin_select ? p3_in[`PTMUX_PIN_WAIT] : 1'b1; // [RULE_03]
            converter_trigger_input <= periph_sel_ff[`PTMUX_BIT_EXT_TRIGGER_ENABLE] ? p4_in[0] : 1'b1; // [RULE_13]
            // These always follow the pin; the timer decides whether to use them
            timer_two_ext_clock_in <= p4_in[7]; // [RULE_09]
            timer_one_ext_clock_in <= p4_in[5]; // [RULE_09]
            timer_two_capture_in <= p4_in[6]; // [RULE_17]
            timer_one_capture_in <= p4_in[4]; // [RULE_17]
            timer8_reset_input <= p4_in[2]; // [RULE_11]
            timer8_clock_input <= p4_in[1]; // [RULE_12]
        end
    end
endmodule
`default_nettype wire

// ---- tb/ptmux_pin_model.sv ----
// Board-side pads: each pad level resolved from block drive and board level
`timescale 1ns/1ps
`default_nettype none
module ptmux_pin_model #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] pad_out,
    input wire logic [WIDTH-1:0] pad_oe,
    input wire logic [WIDTH-1:0] board_lvl,
    output logic [WIDTH-1:0] pad_lvl
);
    // A driven pad shows the block's value, an undriven one the board's own level
    assign pad_lvl = (pad_out & pad_oe) | (board_lvl & ~pad_oe);
endmodule
`default_nettype wire

// ---- tb/ptmux_top_asserts.sv ----
// Concurrent checks on the read port and pin routing of the port block
`timescale 1ns/1ps
`default_nettype none
`include "ptmux_consts.svh"
module ptmux_chk #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] power_mode,
    input wire logic wait_pin_select,
    input wire logic [WIDTH-1:0] p3_in,
    input wire logic [WIDTH-1:0] p3_oe,
    input wire logic [WIDTH-1:0] p4_in,
    input wire logic [WIDTH-1:0] p4_oe,
    input wire logic [WIDTH-1:0] p5_oe,
    input wire logic wait_request_in,
    input wire logic timer_one_capture_in,
    input wire logic timer_two_capture_in,
    input wire logic timer_one_ext_clock_in,
    input wire logic timer_two_ext_clock_in,
    input wire logic timer8_reset_input,
    input wire logic timer8_clock_input
);
    // One clock domain; $past terms are gated on the edge after reset release
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    dir_read_a: assert property (reg_rd && reg_addr inside {`PTMUX_ADDR_P3_DIR,
        `PTMUX_ADDR_P4_DIR, `PTMUX_ADDR_P5_DIR} |=> reg_rdata == 8'hFF) else $error("dir read");
    brc_read_a: assert property (reg_rd && reg_addr == `PTMUX_ADDR_BRC
        |=> reg_rdata[7:1] == 7'h7F) else $error("release reg upper bits");
    rdata_idle_a: assert property (!$past(reg_rd) && !$past(rst)
        |-> reg_rdata == 8'h00) else $error("rdata without read");
    wait_route_a: assert property (!$past(rst) |-> wait_request_in ==
        ($past(wait_pin_select) ? $past(p3_in[0]) : 1'b1)) else $error("wait route");
    capture_route_a: assert property (!$past(rst) |-> {timer_two_capture_in,
        timer_one_capture_in} == $past({p4_in[6], p4_in[4]})) else $error("capture route");
    ext_clk_a: assert property (!$past(rst) |-> {timer_two_ext_clock_in,
        timer_one_ext_clock_in} == $past({p4_in[7], p4_in[5]})) else $error("clock route");
    t8_inputs_a: assert property (!$past(rst) |-> {timer8_reset_input,
        timer8_clock_input} == $past(p4_in[2:1])) else $error("timer8 inputs");
    hw_stby_oe_a: assert property ((power_mode == 2'h2) [*2] |=>
        (p3_oe | p4_oe | p5_oe) == 8'h00) else $error("drive in hw standby");
endmodule
bind ptmux_top ptmux_chk #(.WIDTH(WIDTH)) ptmux_chk_inst (.*);
`default_nettype wire

// ---- tb/ptmux_tb_top.sv ----
// Self-checking bench for the port 3-5 block
`timescale 1ns/1ps
`default_nettype none
`include "ptmux_consts.svh"
module ptmux_tb_top;
    logic clk_sys, rst, reg_wr, reg_rd, wait_pin_select, bus_grant_out, rd_d;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, b3, b4, b5, p3_in, p4_in, p5_in, d, l;
    logic [7:0] p3_out, p3_oe, p4_out, p4_oe, p5_out, p5_oe, exp_q[$];
    logic [1:0] power_mode;
    logic bus_request_input, wait_request_in, converter_trigger_input, timer8_wave_output;
    logic timer_one_ext_clock_in, timer_two_ext_clock_in, timer8_reset_input;
    logic timer_one_capture_in, timer_two_capture_in, timer8_clock_input;
    logic timer_one_compare_out_a, timer_one_compare_out_b;
    logic timer_two_compare_out_a, timer_two_compare_out_b;
    int n_errors = 0, checks_done = 0, cyc = 0;
    ptmux_top ptmux_top_inst (.*);
    ptmux_pin_model m3 (.pad_out(p3_out), .pad_oe(p3_oe), .board_lvl(b3), .pad_lvl(p3_in));
    ptmux_pin_model m4 (.pad_out(p4_out), .pad_oe(p4_oe), .board_lvl(b4), .pad_lvl(p4_in));
    ptmux_pin_model m5 (.pad_out(p5_out), .pad_oe(p5_oe), .board_lvl(b5), .pad_lvl(p5_in));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Each access waits an edge first, so strobes never get two drives in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(want);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Read data stand only in the cycle after the strobe; also cuts a hang short
    always @(posedge clk_sys) begin
        if (rd_d) check("rdata", reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd && !rst;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h0b7f));
        {reg_addr, reg_wdata, reg_wr, reg_rd, power_mode, wait_pin_select, rd_d} = '0;
        {b3, b4, b5} = 24'($urandom);
        {bus_grant_out, timer8_wave_output} = 2'b10;
        {timer_two_compare_out_b, timer_two_compare_out_a} = 2'b10;
        {timer_one_compare_out_b, timer_one_compare_out_a} = 2'b01;
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`PTMUX_ADDR_BRC, `PTMUX_BRC_RST);
        rd(`PTMUX_ADDR_P4_LAT, b4);
        rd(16'h0000, 8'h00);
        for (int p = 0; p < 2; p++) begin
            d = $urandom;
            l = $urandom;
            wr(p ? `PTMUX_ADDR_P5_DIR : `PTMUX_ADDR_P4_DIR, d);
            wr(p ? `PTMUX_ADDR_P5_LAT : `PTMUX_ADDR_P4_LAT, l);
            rd(p ? `PTMUX_ADDR_P5_DIR : `PTMUX_ADDR_P4_DIR, 8'hFF);
            rd(p ? `PTMUX_ADDR_P5_LAT : `PTMUX_ADDR_P4_LAT, (l & d) | ((p ? b5 : b4) & ~d));
            check("oe", p ? p5_oe : p4_oe, d);
            check("out", (p ? p5_out : p4_out) & d, l & d);
        end
        power_mode <= 2'h1;
        rd(`PTMUX_ADDR_P5_LAT, (l & d) | (b5 & ~d));
        check("sw stby oe", p5_oe, d);
        power_mode <= 2'h2;
        wr(`PTMUX_ADDR_P5_LAT, 8'hFF);
        rd(`PTMUX_ADDR_P5_LAT, b5);
        power_mode <= 2'h0;
        wr(`PTMUX_ADDR_PERIPH, 8'h7E);
        // Pin registers update at the edge the task returns on; look once they settle
        @(negedge clk_sys);
        check("cmp", {p5_oe[3:0], p5_out[3:0]}, 8'hF9);
        check("wave", {p4_oe[3], p4_out[3], p4_oe[0], converter_trigger_input}, {3'h4, b4[0]});
        check("p4 feeds", {timer_two_ext_clock_in, timer_two_capture_in, timer_one_ext_clock_in,
            timer_one_capture_in, timer8_reset_input, timer8_clock_input}, {b4[7:4], b4[2:1]});
        power_mode <= 2'h1;
        wr(`PTMUX_ADDR_P3_DIR, 8'h07);
        @(negedge clk_sys);
        check("sw stby cmp", p5_oe, 8'h00);
        power_mode <= 2'h0;
        wr(`PTMUX_ADDR_BRC, 8'h01);
        wait_pin_select <= 1'b1;
        rd(`PTMUX_ADDR_BRC, 8'hFF);
        check("release", {p3_oe[2:0], p3_out[1], bus_request_input}, {5'h2, bus_grant_out, b3[2]});
        check("wait", {p3_oe[0], wait_request_in}, {1'b0, b3[0]});
        wr(`PTMUX_ADDR_BRC, 8'h00);
        @(negedge clk_sys);
        check("plain p3", {p3_oe[2:1], bus_request_input}, 3'h7);
        end_sim();
    end
endmodule
`default_nettype wire
